// File: rtl/zero_wait_pkg.sv
// constants shared by the zero-wait host read port and its word store
// assumes a 10 MHz system clock on pclk
package zero_wait_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int INTERNAL_TRANSFER_ACTIVE_N_WIDTH_NS = 400;
    localparam int UNCONT_NS = 205;
    localparam int CONT_SLOW_NS = 7200;
    localparam int CONT_FAST_NS = 700;
    localparam int SYNC_CYC = 2;
    // nominal width, rounded up
    localparam logic [7:0] INTERNAL_TRANSFER_ACTIVE_N_CYC = 8'((INTERNAL_TRANSFER_ACTIVE_N_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // longest times, rounded down
    localparam logic [7:0] UNCONT_CYC = 8'(UNCONT_NS / CLK_PERIOD_NS);
    localparam logic [7:0] CONT_SLOW_CYC = 8'(CONT_SLOW_NS / CLK_PERIOD_NS);
    localparam logic [7:0] CONT_FAST_CYC = 8'(CONT_FAST_NS / CLK_PERIOD_NS);
    // wait budget left once the strobe has crossed the synchroniser
    localparam logic [7:0] SLOW_WAIT = CONT_SLOW_CYC - 8'(SYNC_CYC + 1);
    localparam logic [7:0] FAST_WAIT = CONT_FAST_CYC - 8'(SYNC_CYC + 1);
    localparam int RAM_WORDS = 65536;
    localparam int REG_WORDS = 32;
    localparam int RAM4K_BITS = 12;
    localparam int REG_BITS = 5;
    // apb map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] LOAD_ADDR_OFS = 12'h008;
    localparam logic [11:0] LOAD_DATA_OFS = 12'h00C;
    localparam int CTRL_FAST_BIT = 0;
    localparam int CTRL_RAM64_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int LOAD_SEL_BIT = 16;
    localparam logic [16:0] LOAD_ADDR_RST = 17'h00000;
    localparam int ST_SEL_BIT = 16;
    localparam int ST_DIR_BIT = 17;
    localparam int ST_INTERNAL_TRANSFER_ACTIVE_N_BIT = 18;
    localparam int ST_READY_BIT = 19;
    localparam int ST_BLOCK_BIT = 20;
    localparam int ST_FORCE_BIT = 21;
    // sync vector: ce, strobe, dir, sel, strap, sense, addr[15:0]
    localparam logic [21:0] SYNC_RST = 22'h300000;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_BLOCKED, ST_ARB, ST_XFER, ST_DONE
    } port_state_t;
endpackage : zero_wait_pkg

// File: rtl/store_if.sv
// request and answer signals between the port sequencer and its word store
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface store_if;
    logic rd_en;
    logic rd_mem;
    logic [15:0] rd_addr;
    logic [15:0] rd_data;
    logic wr_en;
    logic wr_mem;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    modport port (output rd_en, rd_mem, rd_addr, wr_en, wr_mem, wr_addr, wr_data,
                  input rd_data);
    modport store (input rd_en, rd_mem, rd_addr, wr_en, wr_mem, wr_addr, wr_data,
                   output rd_data);
endinterface : store_if

// File: rtl/zero_wait_store.sv
// word store: shared ram and the register set, one read and one write port
// assumes addresses arrive already decoded to the selected space
`timescale 1ns/1ps
module zero_wait_store
    import zero_wait_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    store_if.store bus
);
    logic [15:0] ram_mem [RAM_WORDS];
    logic [15:0] reg_ff [REG_WORDS];
    logic [15:0] rd_data_ff;

    // ram has no reset: contents are whatever software loaded
    always_ff @(posedge pclk) begin
        if (bus.wr_en && bus.wr_mem) begin
            ram_mem[bus.wr_addr] <= bus.wr_data;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < REG_WORDS; gi++) begin : g_reg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    reg_ff[gi] <= 16'h0000;
                end else if (bus.wr_en && !bus.wr_mem && bus.wr_addr[REG_BITS-1:0] == gi) begin
                    reg_ff[gi] <= bus.wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_ff <= 16'h0000;
        end else if (bus.rd_en) begin
            rd_data_ff <= bus.rd_mem ? ram_mem[bus.rd_addr] : reg_ff[bus.rd_addr[REG_BITS-1:0]];
        end
    end

    assign bus.rd_data = rd_data_ff;
endmodule : zero_wait_store

// File: rtl/zero_wait_host_read_port.sv
// zero-wait pipelined host read port with apb control and status
// assumes host pins are asynchronous to pclk; protocol_ram_busy is on pclk
// Operation
// RQ1: board ties pipelined_read_strap low to select zero-wait reads.
// RQ2: trigger choice and byte order straps are ignored here.
// RQ3: transfer enable falls when ready low, strobe high and ram free.
// RQ4: type and direction pass through until strobe rise or second edge.
// RQ5: address passes through until strobe rise or second edge.
// RQ6: direction sense strap chooses which level of the direction pin reads.
// RQ7: each read returns data fetched for the previous access's address.
// RQ8: ram decoded on 16 or 12 lines, registers on five lines.
// RQ9: host issues two accesses per word and discards the first data.
// RQ10: in bursts the host presents the next address with current data.
// RQ11: chip enable release before second edge acts as strobe rise.
// RQ12: both enables low start a transfer; late chip enable blocks it.
// RQ13: transfer enable stays low the nominal width for ram and registers.
// RQ14: transfer enable ends on a rising edge, ready rises on falling.
// RQ15: start bounds at 20 MHz, uncontended and contended by arbitration.
// RQ16: start bounds at 10 MHz, uncontended and contended by arbitration.
// RQ17: host waits the minimum time before starting the next transfer.
// RQ18: host may lower strobe as soon as ready returns high.
// RQ19: host drives type select high for ram, low for registers.
// RQ20: transfer enable low pulse lasts four system clock periods.
// RQ21: latched address and type select the next access's data.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module zero_wait_host_read_port
    import zero_wait_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_enable_n,
    input wire logic host_strobe_n,
    input wire logic read_write_dir,
    input wire logic memory_or_register_sel,
    input wire logic [15:0] address_lines,
    input wire logic pipelined_read_strap,
    input wire logic rw_sense_strap,
    input wire logic trigger_input_choice,
    input wire logic byte_order_strap,
    input wire logic protocol_ram_busy,
    output logic host_ram_request,
    output logic protocol_stall,
    output logic internal_transfer_active_n,
    output logic host_ready_n,
    output logic [15:0] data_lines_o,
    output logic data_lines_oe,
    output logic [15:0] addr_view,
    output logic sel_view,
    output logic dir_view
);
    store_if st();

    logic [21:0] sync_s1_ff;
    logic [21:0] sync_s2_ff;
    logic ce_n_s;
    logic stb_n_s;
    logic dir_s;
    logic sel_s;
    logic strap_s;
    logic sense_s;
    logic [15:0] addr_s;
    port_state_t state_ff;
    logic edge1_ff;
    logic ce_seen_ff;
    logic [15:0] addr_ff;
    logic sel_ff;
    logic dir_ff;
    logic [7:0] wait_cnt_ff;
    logic [7:0] xfer_cnt_ff;
    logic internal_transfer_active_n_n_ff;
    logic pending_ff;
    logic ready_n_neg_ff;
    logic forced_ff;
    logic blocked_ff;
    logic [15:0] data_ff;
    logic [1:0] ctrl_ff;
    logic [16:0] load_addr_ff;
    logic [31:0] prdata_ff;
    logic [7:0] limit;
    logic limit_hit;
    logic grant;
    logic capture;
    logic is_read;
    logic apb_write;
    logic unmapped;
    logic [31:0] status_word;

    // RQ2: trigger_input_choice and byte_order_strap have no effect here
    // host pins are asynchronous: two flops before any logic reads them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_s1_ff <= SYNC_RST;
            sync_s2_ff <= SYNC_RST;
        end else begin
            sync_s1_ff <= {chip_enable_n, host_strobe_n, read_write_dir, memory_or_register_sel,
                           pipelined_read_strap, rw_sense_strap, address_lines};
            sync_s2_ff <= sync_s1_ff;
        end
    end

    assign {ce_n_s, stb_n_s, dir_s, sel_s, strap_s, sense_s, addr_s} = sync_s2_ff;

    // capture on strobe rise, chip enable release or second edge with both low
    assign capture = (state_ff == ST_SETUP) && (stb_n_s || (ce_n_s && ce_seen_ff) ||
                     (edge1_ff && !ce_n_s)); // RQ4 RQ5 RQ11
    assign limit = ctrl_ff[CTRL_FAST_BIT] ? FAST_WAIT : SLOW_WAIT; // RQ15 RQ16
    assign limit_hit = (wait_cnt_ff >= limit);
    // protocol logic is expected to yield once it sees the request; past the
    // budget the host is granted anyway and the protocol side is stalled
    assign grant = (state_ff == ST_ARB) && stb_n_s && (!protocol_ram_busy || limit_hit); // RQ3
    assign is_read = (dir_s == sense_s); // RQ6

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (!strap_s && !stb_n_s) begin // RQ1
                        state_ff <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (capture) begin
                        state_ff <= (ce_seen_ff || !ce_n_s) ? ST_ARB : ST_IDLE; // RQ12
                    end else if (edge1_ff) begin
                        state_ff <= ST_BLOCKED; // RQ12
                    end
                end
                ST_BLOCKED: begin
                    if (stb_n_s) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_ARB: begin
                    if (grant) begin
                        state_ff <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (xfer_cnt_ff == 8'h00) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // edge count and chip-enable history inside the setup window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge1_ff <= 1'b0;
            ce_seen_ff <= 1'b0;
        end else if (state_ff == ST_SETUP) begin
            edge1_ff <= 1'b1;
            ce_seen_ff <= ce_seen_ff || !ce_n_s;
        end else begin
            edge1_ff <= 1'b0;
            ce_seen_ff <= (state_ff == ST_IDLE) && !ce_n_s;
        end
    end

    // latched values live until the next capture so they pick the next data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff <= 16'h0000;
            sel_ff <= 1'b0;
            dir_ff <= 1'b0;
        end else if (capture) begin
            addr_ff <= addr_s; // RQ5 RQ21
            sel_ff <= sel_s; // RQ4 RQ21
            dir_ff <= dir_s; // RQ4
        end
    end

    // transparent until latched
    assign addr_view = (state_ff == ST_SETUP) ? addr_s : addr_ff; // RQ5
    assign sel_view = (state_ff == ST_SETUP) ? sel_s : sel_ff; // RQ4
    assign dir_view = (state_ff == ST_SETUP) ? dir_s : dir_ff; // RQ4

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_ff <= 8'h00;
        end else if (state_ff == ST_ARB && stb_n_s && !grant) begin
            wait_cnt_ff <= wait_cnt_ff + 8'h01;
        end else if (state_ff != ST_ARB) begin
            wait_cnt_ff <= 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_transfer_active_n_n_ff <= 1'b1;
            xfer_cnt_ff <= 8'h00;
            forced_ff <= 1'b0;
        end else if (grant) begin
            internal_transfer_active_n_n_ff <= 1'b0; // RQ3
            xfer_cnt_ff <= INTERNAL_TRANSFER_ACTIVE_N_CYC - 8'h01; // RQ13 RQ20
            forced_ff <= protocol_ram_busy;
        end else if (state_ff == ST_XFER) begin
            xfer_cnt_ff <= xfer_cnt_ff - 8'h01;
            if (xfer_cnt_ff == 8'h00) begin
                internal_transfer_active_n_n_ff <= 1'b1; // RQ14
                forced_ff <= 1'b0;
            end
        end
    end

    // ready low from capture until the transfer enable has ended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_ff <= 1'b0;
        end else if (capture && (ce_seen_ff || !ce_n_s)) begin
            pending_ff <= 1'b1;
        end else if (state_ff == ST_XFER && xfer_cnt_ff == 8'h00) begin
            pending_ff <= 1'b0;
        end
    end

    // ready moves on the falling edge, half a cycle after the rising edge
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_n_neg_ff <= 1'b1;
        end else begin
            ready_n_neg_ff <= !pending_ff; // RQ14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blocked_ff <= 1'b0;
        end else if (state_ff == ST_BLOCKED) begin
            blocked_ff <= 1'b1;
        end else if (state_ff == ST_ARB) begin
            blocked_ff <= 1'b0;
        end
    end

    // fetch for the latched location; word is handed out on the next access
    assign st.rd_en = grant; // RQ7
    assign st.rd_mem = sel_ff;
    assign st.rd_addr = sel_ff ? (ctrl_ff[CTRL_RAM64_BIT] ? addr_ff :
                        {4'h0, addr_ff[RAM4K_BITS-1:0]}) :
                        {11'h000, addr_ff[REG_BITS-1:0]}; // RQ8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= 16'h0000;
        end else if (state_ff == ST_XFER && xfer_cnt_ff == 8'h00) begin
            data_ff <= st.rd_data; // RQ7
        end
    end

    assign data_lines_o = data_ff;
    assign data_lines_oe = !strap_s && !ce_n_s && !stb_n_s && is_read; // RQ6
    assign internal_transfer_active_n = internal_transfer_active_n_n_ff;
    assign host_ready_n = ready_n_neg_ff;
    assign host_ram_request = (state_ff == ST_ARB);
    assign protocol_stall = forced_ff;

    zero_wait_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .bus(st)
    );

    // apb slave, always ready; unmapped offsets answer with pslverr
    assign apb_write = psel && penable && pwrite;
    assign unmapped = !(paddr == CTRL_OFS || paddr == STATUS_OFS ||
                        paddr == LOAD_ADDR_OFS || paddr == LOAD_DATA_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && unmapped;
    assign prdata = prdata_ff;
    assign status_word = {10'h000, forced_ff, blocked_ff, !ready_n_neg_ff, !internal_transfer_active_n_n_ff,
                          dir_ff, sel_ff, addr_ff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RST;
            load_addr_ff <= LOAD_ADDR_RST;
        end else if (apb_write && paddr == CTRL_OFS) begin
            ctrl_ff <= pwdata[1:0];
        end else if (apb_write && paddr == LOAD_ADDR_OFS) begin
            load_addr_ff <= pwdata[16:0];
        end
    end

    assign st.wr_en = apb_write && (paddr == LOAD_DATA_OFS);
    assign st.wr_mem = load_addr_ff[LOAD_SEL_BIT];
    assign st.wr_addr = load_addr_ff[15:0];
    assign st.wr_data = pwdata[15:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                CTRL_OFS: prdata_ff <= {30'h00000000, ctrl_ff};
                STATUS_OFS: prdata_ff <= status_word;
                LOAD_ADDR_OFS: prdata_ff <= {15'h0000, load_addr_ff};
                default: prdata_ff <= 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    internal_transfer_active_n_width_a: assert property ( // RQ13
        $fell(internal_transfer_active_n) |->
            (!internal_transfer_active_n)[*4] ##1 internal_transfer_active_n)
        else $error("transfer enable width not four cycles");
    start_cond_a: assert property ( // RQ3
        $fell(internal_transfer_active_n) |->
            !$past(host_ready_n) && $past(stb_n_s) &&
            (!$past(protocol_ram_busy) || $past(limit_hit)))
        else $error("transfer started without ready low, strobe high and ram free");
    ready_release_a: assert property ( // RQ14
        $rose(internal_transfer_active_n) |-> host_ready_n && !$past(host_ready_n))
        else $error("ready did not rise half a cycle after transfer end");
    uncont_start_a: assert property ( // RQ16
        (state_ff == ST_ARB && stb_n_s && !protocol_ram_busy) |=> !internal_transfer_active_n)
        else $error("uncontended transfer did not start next edge");
    cont_bound_a: assert property ( // RQ15
        (state_ff == ST_ARB) |-> wait_cnt_ff <= SLOW_WAIT)
        else $error("contended wait exceeded budget");
    fast_arb_a: assert property ( // RQ16
        (state_ff == ST_ARB && stb_n_s && ctrl_ff[CTRL_FAST_BIT] && wait_cnt_ff == FAST_WAIT)
            |=> !internal_transfer_active_n)
        else $error("fast arbitration did not force the transfer");
    latch_hold_a: assert property ( // RQ21
        (state_ff != ST_SETUP) |=> $stable(addr_ff) && $stable(sel_ff))
        else $error("latched address changed outside setup");
    blocked_ce_a: assert property ( // RQ12
        (state_ff == ST_SETUP && edge1_ff && !stb_n_s && ce_n_s && !ce_seen_ff)
            |=> state_ff == ST_BLOCKED ##1 internal_transfer_active_n)
        else $error("late chip enable did not block the transfer");
    data_fetch_a: assert property ( // RQ7
        $rose(internal_transfer_active_n) |-> data_lines_o == $past(st.rd_data))
        else $error("returned word not the fetched one");
    reg_decode_a: assert property ( // RQ8
        (st.rd_en && !st.rd_mem) |-> st.rd_addr[15:REG_BITS] == 11'h000)
        else $error("register read used more than five address lines");
    rw_sense_a: assert property ( // RQ6
        data_lines_oe |-> (dir_s == sense_s))
        else $error("data driven on a write access");
    stall_flag_a: assert property ( // RQ15
        (grant && protocol_ram_busy) |=> protocol_stall)
        else $error("forced grant did not stall the protocol side");

    uncont_c: cover property (state_ff == ST_ARB && !protocol_ram_busy ##1 state_ff == ST_XFER);
    forced_c: cover property (grant && protocol_ram_busy);
    blocked_c: cover property (state_ff == ST_BLOCKED);
    ce_release_c: cover property (capture && ce_n_s && !stb_n_s);
endmodule : zero_wait_host_read_port

// File: tb/host_model.sv
// host processor model: drives the host pins and measures the port's answer
// assumes pins change right after a rising pclk edge; outputs are read at rising edges
`timescale 1ns/1ps
module host_model (
    input wire logic pclk,
    input wire logic internal_transfer_active_n,
    input wire logic host_ready_n,
    input wire logic [15:0] data_lines_o,
    input wire logic data_lines_oe,
    output logic chip_enable_n,
    output logic host_strobe_n,
    output logic read_write_dir,
    output logic memory_or_register_sel,
    output logic [15:0] address_lines
);
    localparam int WAIT_LIM = 120;
    // longest gap after strobe rise: contended, slow arbitration, 10 MHz
    localparam int GAP_CYC = 78;
    logic [15:0] rd_data;
    logic rd_oe, rdy_at_go, rdy_end;
    int lat, width;

    initial begin
        chip_enable_n = 1'b1;
        host_strobe_n = 1'b1;
        read_write_dir = 1'b1;
        memory_or_register_sel = 1'b0;
        address_lines = 16'h0000;
    end

    // mode 0: select with strobe, 1: select dropped after one edge, 2: select never given
    task automatic access(input logic sel, input logic [15:0] adr, input logic rd, input int mode,
                          input int hold);
        int n;
        memory_or_register_sel <= sel;
        address_lines <= adr;
        read_write_dir <= rd;
        host_strobe_n <= 1'b0;
        chip_enable_n <= (mode == 2);
        for (int k = 0; k < hold; k++) begin
            @(posedge pclk);
            if (mode == 1 && k == 0) chip_enable_n <= 1'b1;
            if (mode == 1 && k == 3) address_lines <= ~adr;
        end
        rd_data = data_lines_o;
        rd_oe = data_lines_oe;
        host_strobe_n <= 1'b1;
        chip_enable_n <= 1'b1;
        lat = 0;
        width = 0;
        while (internal_transfer_active_n !== 1'b0 && lat < WAIT_LIM) begin
            @(posedge pclk);
            lat++;
            // released lines must not keep showing the old value
            if (lat == 2) address_lines <= ~adr;
            if (lat == 2) memory_or_register_sel <= ~sel;
        end
        rdy_at_go = host_ready_n;
        while (internal_transfer_active_n === 1'b0 && width < 50) begin
            @(posedge pclk);
            width++;
        end
        rdy_end = host_ready_n;
        n = 0;
        while ((host_ready_n !== 1'b1 || lat + width + n < GAP_CYC) && n < 100) begin
            @(posedge pclk);
            n++;
        end
    endtask : access
endmodule : host_model

// File: tb/zero_wait_host_read_port_tb.sv
// self-checking bench for the zero-wait host read port, host pins driven by host_model
// assumes an apb slave with no wait states and host pins seen two edges late
`timescale 1ns/1ps
module zero_wait_host_read_port_tb
    import zero_wait_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic chip_enable_n, host_strobe_n, read_write_dir, memory_or_register_sel;
    logic [15:0] address_lines, data_lines_o;
    logic pipelined_read_strap, rw_sense_strap, trigger_input_choice, byte_order_strap;
    logic protocol_ram_busy, internal_transfer_active_n, host_ready_n, data_lines_oe;
    int bad_count, n_tests, cyc;

    zero_wait_host_read_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .chip_enable_n, .host_strobe_n, .read_write_dir,
        .memory_or_register_sel, .address_lines, .pipelined_read_strap, .rw_sense_strap,
        .trigger_input_choice, .byte_order_strap, .protocol_ram_busy, .host_ram_request(),
        .protocol_stall(), .internal_transfer_active_n, .host_ready_n, .data_lines_o,
        .data_lines_oe, .addr_view(), .sel_view(), .dir_view());
    host_model i_host (.pclk, .internal_transfer_active_n, .host_ready_n, .data_lines_o,
        .data_lines_oe, .chip_enable_n, .host_strobe_n, .read_write_dir,
        .memory_or_register_sel, .address_lines);

    always #50 pclk = ~pclk;

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic ld(input logic sel, input logic [15:0] adr, input logic [15:0] dat);
        apb(1'b1, LOAD_ADDR_OFS, {15'h0000, sel, adr});
        apb(1'b1, LOAD_DATA_OFS, {16'h0000, dat});
    endtask : ld

    task automatic go(input logic sel, input logic [15:0] adr, input int mode, input int hold);
        i_host.access(sel, adr, rw_sense_strap, mode, hold);
    endtask : go

    // one word read, judged on data, drive, pulse width, ready and start delay
    task automatic rd_chk(input logic sel, input logic [15:0] adr, input logic [15:0] exp,
                          input int lo, input int hi);
        go(sel, adr, 0, 4);
        check(i_host.rd_data, exp, "data");
        check(i_host.rd_oe, 1'b1, "drive");
        check(i_host.width, INTERNAL_TRANSFER_ACTIVE_N_CYC, "width");
        check(i_host.rdy_at_go, 1'b0, "ready at go");
        check(i_host.rdy_end, 1'b1, "ready end");
        check(i_host.lat - 1 > lo && i_host.lat - 1 <= hi, 1'b1, "delay");
    endtask : rd_chk

    task automatic t_regs;
        apb(1'b0, CTRL_OFS, 32'h0);
        check(q[1:0], CTRL_RST, "ctrl reset");
        apb(1'b0, 12'h010, 32'h0);
        check(e, 1'b1, "unmapped err");
        apb(1'b1, CTRL_OFS, 32'(1 << CTRL_RAM64_BIT));
        apb(1'b0, CTRL_OFS, 32'h0);
        check(q[1:0], 2'h2, "ctrl back");
        ld(1'b1, 16'hF123, 16'hA5C3);
        ld(1'b1, 16'h0005, 16'h1234);
        ld(1'b0, 16'h0003, 16'h5A0F);
    endtask : t_regs

    task automatic t_burst;
        go(1'b1, 16'hF123, 0, 4);
        rd_chk(1'b1, 16'h0005, 16'hA5C3, 0, UNCONT_CYC + SYNC_CYC);
        rd_chk(1'b0, 16'h0023, 16'h1234, 0, UNCONT_CYC + SYNC_CYC);
        rd_chk(1'b1, 16'h0005, 16'h5A0F, 0, UNCONT_CYC + SYNC_CYC);
    endtask : t_burst

    task automatic t_latch;
        go(1'b1, 16'hF123, 0, 1);
        rd_chk(1'b0, 16'h0003, 16'hA5C3, 0, UNCONT_CYC + SYNC_CYC);
        go(1'b1, 16'h0005, 1, 5);
        rd_chk(1'b1, 16'hF123, 16'h1234, 0, UNCONT_CYC + SYNC_CYC);
        go(1'b0, 16'h0003, 2, 4);
        check(i_host.width, 0, "blocked");
        apb(1'b0, STATUS_OFS, 32'h0);
        check(q[ST_BLOCK_BIT], 1'b1, "blocked flag");
        rd_chk(1'b1, 16'h0005, 16'hA5C3, 0, UNCONT_CYC + SYNC_CYC);
    endtask : t_latch

    task automatic t_straps;
        pipelined_read_strap <= 1'b1;
        go(1'b1, 16'hF123, 0, 4);
        check(i_host.width, 0, "strap idle");
        check(i_host.rd_oe, 1'b0, "strap drive");
        pipelined_read_strap <= 1'b0;
        rd_chk(1'b0, 16'h0003, 16'h1234, 0, UNCONT_CYC + SYNC_CYC);
        rw_sense_strap <= 1'b0;
        trigger_input_choice <= 1'b1;
        byte_order_strap <= 1'b1;
        // let the new sense settle before the access picks its direction level
        @(posedge pclk);
        rd_chk(1'b1, 16'h0005, 16'h5A0F, 0, UNCONT_CYC + SYNC_CYC);
        rw_sense_strap <= 1'b1;
    endtask : t_straps

    task automatic t_contend;
        protocol_ram_busy <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'(3));
        rd_chk(1'b1, 16'hF123, 16'h1234, SYNC_CYC + 1, CONT_FAST_CYC);
        apb(1'b1, CTRL_OFS, 32'(1 << CTRL_RAM64_BIT));
        rd_chk(1'b1, 16'h0005, 16'hA5C3, CONT_FAST_CYC, CONT_SLOW_CYC);
        protocol_ram_busy <= 1'b0;
        // 4K decode keeps only the low twelve lines
        apb(1'b1, CTRL_OFS, 32'h0);
        go(1'b1, 16'hF005, 0, 4);
        rd_chk(1'b0, 16'h0003, 16'h1234, 0, UNCONT_CYC + SYNC_CYC);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(q, 32'h00020003, "status latch");
    endtask : t_contend

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pipelined_read_strap = 1'b0;
        rw_sense_strap = 1'b1;
        trigger_input_choice = 1'b0;
        byte_order_strap = 1'b0;
        protocol_ram_busy = 1'b0;
        bad_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_burst();
        t_latch();
        t_straps();
        t_contend();
        summarize();
    end
endmodule : zero_wait_host_read_port_tb
